// >>> hdl/upc_pkg.sv
// Package of offsets, field positions and reset values for the update and
// profile control register bank. Assumes nothing of its surroundings.
package upc_pkg;
  localparam logic [12:0] OFF_SPEED = 13'h0002;
  localparam logic [12:0] OFF_UPDATE = 13'h00ff;
  localparam logic [12:0] OFF_PROFILE = 13'h010c;
  localparam logic [12:0] OFF_RSVD_A = 13'h0198;
  localparam logic [12:0] OFF_SAMPLE_CNT = 13'h0199;
  localparam logic [12:0] OFF_RSVD_B = 13'h019a;
  localparam logic [12:0] OFF_RSVD_C = 13'h019b;
  localparam logic [12:0] OFF_FRAME_SIZE = 13'h019c;
  localparam logic [12:0] OFF_RSVD_D = 13'h019d;
  localparam logic [12:0] OFF_RSVD_E = 13'h019e;
  localparam logic [12:0] OFF_PROF_MEM_LO = 13'h0f00;
  localparam logic [12:0] OFF_PROF_MEM_HI = 13'h0fff;
  localparam logic [12:0] OFF_COEF_MEM_LO = 13'h1000;
  localparam logic [12:0] OFF_COEF_MEM_HI = 13'h1fff;
  localparam int PROFILE_IDX_MSB = 4;
  localparam int SOFT_TRIG_BIT = 5;
  localparam int SAMPLE_CNT_EN_BIT = 7;
  localparam int FRAME_AUTO_BIT = 4;
  localparam logic [7:0] RST_SPEED = 8'h00;
  localparam logic [7:0] RST_PROFILE = 8'h00;
  localparam logic [7:0] RST_SAMPLE_CNT = 8'h00;
  localparam logic [7:0] RST_FRAME_SIZE = 8'h10;
  localparam logic [7:0] RST_FRAME_MASK = 8'hfc;
  localparam logic [7:0] RST_RSVD_A = 8'h00;
  localparam logic [7:0] RST_RSVD_B = 8'h00;
  localparam logic [7:0] RST_RSVD_C = 8'h70;
  localparam logic [7:0] RST_RSVD_D = 8'h00;
  localparam logic [7:0] RST_RSVD_E = 8'h10;
  localparam logic [7:0] RST_MEM = 8'h00;
endpackage

// >>> hdl/mem_port_if.sv
// Interface joining the register bank to its byte-wide memory.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface mem_port_if #(parameter int AW = 12);
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

// >>> hdl/byte_mem.sv
// Byte-wide memory holding the profile and coefficient regions.
// Assumes one clock; read data come out one cycle after the address.
`timescale 1ns/10ps
module byte_mem #(
  parameter int AW = 12
) (
  // Clock.
  input wire logic ref_clk,
  // Access port.
  mem_port_if.mem port
);
  logic [7:0] store [0:(1<<AW)-1];
  logic [7:0] rd;

  // Contents are not cleared by reset; a memory this size has no reset path.
  always_ff @(posedge ref_clk) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    rd <= store[port.addr];
  end

  assign port.rdata = rd;
endmodule

// >>> hdl/upc_regs.sv
// Update, profile select and link frame control register bank.
// Assumes a host decoder hands over one byte write or read per cycle.
//
// What this block does
// - Registers act on write; speed waits for update.
// - Update write applies speed, restores analog defaults.
// - Update spares link, offset zero, speed registers.
// - Five-bit profile index selects active profile.
// - Bit five raises internal transmit trigger pulse.
// - Sample counter register bit seven enables counter.
// - Frame size bit four enables auto size.
`timescale 1ns/10ps
module upc_regs
  import upc_pkg::*;
#(
  parameter int MEM_AW = 13
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Register access from the serial port decoder.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [12:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Analog and converter settings, restored by update.
  input wire logic analog_wr,
  input wire logic [7:0] analog_wdata,
  output logic [7:0] analog_cfg,
  // Control outputs.
  output logic [7:0] speed_mode,
  output logic [4:0] profile_index,
  output logic transmit_trigger,
  output logic sample_counter_en,
  output logic frame_size_auto
);

  ////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [7:0] speed_pending;
    logic [7:0] speed_mode;
    logic [7:0] analog_cfg;
    logic [7:0] profile;
    logic [7:0] sample_cnt;
    logic [7:0] frame_size;
    logic trig;
    logic rd_pend;
    logic rd_mem;
    logic [7:0] rd_hold;
    logic rvalid;
    logic [7:0] rdata;
  } state_t;

  state_t cur;
  state_t next_cur;

  mem_port_if #(.AW(MEM_AW)) mp ();

  byte_mem #(.AW(MEM_AW)) u_mem (
    .ref_clk(ref_clk),
    .port(mp.mem)
  );

  logic in_mem;
  logic [7:0] rd_value;

  // Profile memory is 0xf00..0xfff, coefficients 0x1000..0x1fff: one flat space.
  assign in_mem = reg_addr >= OFF_PROF_MEM_LO;
  assign mp.we = reg_wr && in_mem;
  assign mp.addr = reg_addr[MEM_AW-1:0];
  assign mp.wdata = reg_wdata;

  ////////////////////////////////////////////////////////////////////////
  // Read mux.

  always_comb begin
    case (reg_addr)
      OFF_SPEED: rd_value = cur.speed_pending;
      OFF_PROFILE: rd_value = cur.profile;
      OFF_RSVD_A: rd_value = RST_RSVD_A;
      OFF_SAMPLE_CNT: rd_value = cur.sample_cnt;
      OFF_RSVD_B: rd_value = RST_RSVD_B;
      OFF_RSVD_C: rd_value = RST_RSVD_C;
      OFF_FRAME_SIZE: rd_value = cur.frame_size;
      OFF_RSVD_D: rd_value = RST_RSVD_D;
      OFF_RSVD_E: rd_value = RST_RSVD_E;
      default: rd_value = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_cur = cur;
    next_cur.trig = 1'b0;
    // Reads take two cycles so that read data leave the block from a flip-flop,
    // whether they come from a register or from the memory's own register.
    next_cur.rd_pend = reg_rd;
    next_cur.rd_mem = reg_rd && in_mem;
    if (reg_rd) begin
      next_cur.rd_hold = rd_value;
    end
    next_cur.rvalid = cur.rd_pend;
    if (cur.rd_pend) begin
      next_cur.rdata = cur.rd_mem ? mp.rdata : cur.rd_hold;
    end
    if (analog_wr) begin
      next_cur.analog_cfg = analog_wdata;
    end
    if (reg_wr) begin
      case (reg_addr)
        OFF_SPEED: next_cur.speed_pending = reg_wdata;
        OFF_UPDATE: begin
          // Speed and link registers are untouched here on purpose.
          next_cur.speed_mode = cur.speed_pending;
          next_cur.analog_cfg = RST_SPEED;
        end
        OFF_PROFILE: begin
          next_cur.profile = reg_wdata;
          next_cur.trig = reg_wdata[SOFT_TRIG_BIT];
        end
        OFF_SAMPLE_CNT: next_cur.sample_cnt = reg_wdata & 8'h80;
        OFF_FRAME_SIZE: next_cur.frame_size = reg_wdata & RST_FRAME_MASK;
        default: next_cur = next_cur;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur <= '{speed_pending: RST_SPEED, speed_mode: RST_SPEED, analog_cfg: RST_SPEED,
               profile: RST_PROFILE, sample_cnt: RST_SAMPLE_CNT,
               frame_size: RST_FRAME_SIZE, trig: 1'b0, rd_pend: 1'b0,
               rd_mem: 1'b0, rd_hold: RST_MEM, rvalid: 1'b0, rdata: RST_MEM};
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign reg_rdata = cur.rdata;
  assign reg_rvalid = cur.rvalid;
  assign analog_cfg = cur.analog_cfg;
  assign speed_mode = cur.speed_mode;
  assign profile_index = cur.profile[PROFILE_IDX_MSB:0];
  // The trigger is a one-cycle pulse with no relation to the sample clock.
  assign transmit_trigger = cur.trig;
  assign sample_counter_en = cur.sample_cnt[SAMPLE_CNT_EN_BIT];
  assign frame_size_auto = cur.frame_size[FRAME_AUTO_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_update_wr;
    reg_wr && reg_addr == OFF_UPDATE;
  endsequence

  sequence s_speed_wr;
    reg_wr && reg_addr == OFF_SPEED && !(reg_wr && reg_addr == OFF_UPDATE);
  endsequence

  sequence s_trig_wr;
    reg_wr && reg_addr == OFF_PROFILE && reg_wdata[SOFT_TRIG_BIT];
  endsequence

  sequence s_rsvd_wr;
    reg_wr && (reg_addr == OFF_RSVD_A || reg_addr == OFF_RSVD_B || reg_addr == OFF_RSVD_C
      || reg_addr == OFF_RSVD_D || reg_addr == OFF_RSVD_E);
  endsequence

  sequence s_read_req;
    reg_rd;
  endsequence

  a_speed_held: assert property (@(posedge ref_clk) disable iff (rst)
    s_speed_wr |=> speed_mode == $past(speed_mode))
    else $error("speed changed without update");
  a_update_applies: assert property (@(posedge ref_clk) disable iff (rst)
    s_update_wr |=> speed_mode == $past(cur.speed_pending) && analog_cfg == RST_SPEED)
    else $error("update did not apply speed or restore analog");
  a_update_spares: assert property (@(posedge ref_clk) disable iff (rst)
    s_update_wr |=> frame_size_auto == $past(frame_size_auto)
      && sample_counter_en == $past(sample_counter_en))
    else $error("update touched link registers");
  a_profile_sel: assert property (@(posedge ref_clk) disable iff (rst)
    reg_wr && reg_addr == OFF_PROFILE |=> profile_index == $past(reg_wdata[4:0]))
    else $error("profile index not taken");
  a_trig_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    transmit_trigger |-> $past(reg_wr && reg_addr == OFF_PROFILE && reg_wdata[SOFT_TRIG_BIT]))
    else $error("trigger not a write pulse");
  a_trig_raised: assert property (@(posedge ref_clk) disable iff (rst)
    s_trig_wr |=> transmit_trigger)
    else $error("trigger write gave no pulse");
  a_sample_en: assert property (@(posedge ref_clk) disable iff (rst)
    reg_wr && reg_addr == OFF_SAMPLE_CNT |=> sample_counter_en == $past(reg_wdata[7]))
    else $error("sample counter enable wrong");
  a_frame_auto: assert property (@(posedge ref_clk) disable iff (rst)
    reg_wr && reg_addr == OFF_FRAME_SIZE |=> frame_size_auto == $past(reg_wdata[4]))
    else $error("frame auto enable wrong");
  a_rsvd_read: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_RSVD_C |-> ##2 reg_rvalid && reg_rdata == RST_RSVD_C)
    else $error("reserved read not default");
  a_rsvd_a_read: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_RSVD_A |-> ##2 reg_rvalid && reg_rdata == RST_RSVD_A)
    else $error("reserved read not default");
  a_rsvd_b_read: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_RSVD_B |-> ##2 reg_rvalid && reg_rdata == RST_RSVD_B)
    else $error("reserved read not default");
  a_rsvd_d_read: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_RSVD_D |-> ##2 reg_rvalid && reg_rdata == RST_RSVD_D)
    else $error("reserved read not default");
  a_rsvd_e_read: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_RSVD_E |-> ##2 reg_rvalid && reg_rdata == RST_RSVD_E)
    else $error("reserved read not default");
  // A reserved write must leave the profile, speed, sample counter and frame size outputs as they were.
  a_rsvd_wr_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    s_rsvd_wr |=> $stable(profile_index) && $stable(speed_mode)
      && $stable(sample_counter_en) && $stable(frame_size_auto))
    else $error("reserved write changed a control");
  a_read_answer: assert property (@(posedge ref_clk) disable iff (rst)
    s_read_req |-> ##2 reg_rvalid)
    else $error("read gave no answer");
  a_speed_only_update: assert property (@(posedge ref_clk) disable iff (rst)
    !s_update_wr |=> $stable(speed_mode))
    else $error("speed changed outside update");
  a_analog_write: assert property (@(posedge ref_clk) disable iff (rst)
    analog_wr && !(reg_wr && reg_addr == OFF_UPDATE) |=> analog_cfg == $past(analog_wdata))
    else $error("analog write not taken");
  a_update_keeps_pending: assert property (@(posedge ref_clk) disable iff (rst)
    s_update_wr |=> $stable(cur.speed_pending))
    else $error("update touched speed register");
  // Unused sample counter bits and the two low frame size bits never hold ones, so reads stay predictable.
  a_sample_low_zero: assert property (@(posedge ref_clk) disable iff (rst)
    cur.sample_cnt[6:0] == 7'h00)
    else $error("sample counter low bits set");
  a_frame_low_zero: assert property (@(posedge ref_clk) disable iff (rst)
    cur.frame_size[1:0] == 2'b00)
    else $error("frame size low bits set");
endmodule

// >>> testbench/upc_host.sv
// Host controller model that drives the register port of the bank.
// Assumes a shared ref_clk and that tasks are called after reset.
`timescale 1ns/10ps
module upc_host (
  // Clock.
  input wire logic ref_clk,
  // Register port.
  output logic reg_wr,
  output logic reg_rd,
  output logic [12:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 13'h0000;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    // Released lines flip so a stale value can never pass for fresh data.
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    int n;
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    for (n = 0; n < 3 && reg_rvalid !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule

// >>> testbench/upc_regs_tb_top.sv
// Self-checking bench for the update and profile control register bank.
// Assumes upc_pkg and the host model are compiled first.
`timescale 1ns/10ps
module upc_regs_tb_top;
  import upc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid, analog_wr, transmit_trigger;
  logic sample_counter_en, frame_size_auto;
  logic [12:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, analog_wdata, analog_cfg, speed_mode, d;
  logic [4:0] profile_index;
  int miscompares = 0;
  int checks = 0;
  always #4 ref_clk = ~ref_clk;
  upc_regs i_upc_regs (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .analog_wr(analog_wr), .analog_wdata(analog_wdata),
    .analog_cfg(analog_cfg), .speed_mode(speed_mode), .profile_index(profile_index),
    .transmit_trigger(transmit_trigger), .sample_counter_en(sample_counter_en),
    .frame_size_auto(frame_size_auto));
  upc_host i_upc_host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic t_update;
    @(posedge ref_clk);
    #1;
    analog_wdata = 8'h5c;
    analog_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    analog_wr = 1'b0;
    // Speed first, then the update, before any other setup write.
    i_upc_host.wr(OFF_SPEED, 8'h03);
    chk(speed_mode, 8'h00);
    i_upc_host.wr(OFF_UPDATE, 8'h9e);
    @(posedge ref_clk);
    #1;
    chk(speed_mode, 8'h03);
    chk(analog_cfg, 8'h00);
    i_upc_host.wr(OFF_SAMPLE_CNT, 8'hff);
    chk({7'h00, sample_counter_en}, 8'h01);
    i_upc_host.wr(OFF_FRAME_SIZE, 8'h00);
    i_upc_host.wr(OFF_UPDATE, 8'h00);
    @(posedge ref_clk);
    #1;
    chk({7'h00, sample_counter_en}, 8'h01);
    chk({7'h00, frame_size_auto}, 8'h00);
    i_upc_host.rd(OFF_SAMPLE_CNT, d);
    chk(d, 8'h80);
    i_upc_host.rd(OFF_SPEED, d);
    chk(d, 8'h03);
    $display("test update done");
  endtask
  task automatic t_profile;
    // One bank only, so the register trigger needs no cross-device alignment.
    i_upc_host.wr(OFF_PROFILE, 8'h25);
    chk({3'h0, profile_index}, 8'h05);
    chk({7'h00, transmit_trigger}, 8'h01);
    @(posedge ref_clk);
    #1;
    chk({7'h00, transmit_trigger}, 8'h00);
    i_upc_host.wr(OFF_PROFILE, 8'h1f);
    chk({3'h0, profile_index}, 8'h1f);
    chk({7'h00, transmit_trigger}, 8'h00);
    $display("test profile done");
  endtask
  task automatic t_reserved;
    logic [12:0] a [5] = '{OFF_RSVD_A, OFF_RSVD_B, OFF_RSVD_C, OFF_RSVD_D, OFF_RSVD_E};
    logic [7:0] v [5] = '{8'h00, 8'h00, 8'h70, 8'h00, 8'h10};
    for (int i = 0; i < 5; i++) begin
      i_upc_host.wr(a[i], 8'ha5);
      i_upc_host.rd(a[i], d);
      chk(d, v[i]);
    end
    i_upc_host.wr(OFF_FRAME_SIZE, 8'hff);
    i_upc_host.rd(OFF_FRAME_SIZE, d);
    chk(d, 8'hfc);
    i_upc_host.wr(OFF_PROF_MEM_LO, 8'h5a);
    i_upc_host.wr(OFF_COEF_MEM_HI, 8'hc3);
    i_upc_host.rd(OFF_PROF_MEM_LO, d);
    chk(d, 8'h5a);
    i_upc_host.rd(OFF_COEF_MEM_HI, d);
    chk(d, 8'hc3);
    $display("test reserved done");
  endtask
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    analog_wr = 1'b0;
    analog_wdata = 8'h00;
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    chk({7'h00, frame_size_auto}, 8'h01);
    chk({7'h00, sample_counter_en}, 8'h00);
    t_update();
    t_profile();
    t_reserved();
    print_verdict();
  end
  // Whole run is under a hundred cycles; this limit only catches a hung handshake.
  initial begin
    #50000;
    miscompares++;
    print_verdict();
  end
endmodule
